// >>> core/trc_pkg.sv
// Purpose: Shared constants for the table and range compare unit.
// Assumes: Function codes are carried as three BCD digits in 12 bits.
// Notes: Register offsets are byte addresses on a 32-bit Wishbone bus.
package trc_pkg;

	// Function codes of the four compare operations.
	localparam logic [11:0] OP_TABLE_CMP = 12'h085;
	localparam logic [11:0] OP_BLOCK_CMP = 12'h068;
	localparam logic [11:0] OP_RANGE_CMP = 12'h088;
	localparam logic [11:0] OP_DRANGE_CMP = 12'h116;

	// Geometry of the operand block.
	localparam int WORD_W = 16;
	localparam int N_RANGES = 16;

	// Register byte offsets.
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_FLAGS = 4'h4;
	localparam logic [3:0] OFS_RESULT = 4'h8;

	// Bit positions in the flag register.
	localparam int FL_ER = 0;
	localparam int FL_EQ = 1;
	localparam int FL_GT = 2;
	localparam int FL_LT = 3;
	localparam int FL_GE = 4;
	localparam int FL_LE = 5;
	localparam int FL_NE = 6;
	localparam int FL_N = 7;

	// Reset values.
	localparam logic CTRL_RST = 1'h1;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [15:0] RESULT_RST = 16'h0000;

	// Cycles from issue to completion.
	localparam int DONE_LAT = 1;

endpackage

// >>> core/trc_unit.sv
// Purpose: Table, block and range compare datapath for the CPU sequencer.
// Assumes: Operands are held stable by the sequencer until done_o.
// Notes: Comparisons are unsigned; flags are also reachable over Wishbone.
// Operation
// RULE_01 - Table compare: bit n set when table word n equals source.
// RULE_02 - Table compare: equal flag set only for zero result; error flag cleared.
// RULE_03 - Block of 32 words: even word is lower bound, odd word upper bound.
// RULE_04 - Block compare bit n set when source inside range n, bounds included.
// RULE_05 - Inverted block range gives no error and a zero result bit.
// RULE_06 - Block compare: equal flag set only for zero result; error flag cleared.
// RULE_07 - Block compare has its own code and evaluates all sixteen ranges at once.
// RULE_08 - Single range compare uses 16-bit value and limits, flags only.
// RULE_09 - Double range compare uses 32-bit value and limits, flags only.
// RULE_10 - Range compare: greater above high, equal inside, less below low.
// RULE_11 - Range compare keeps ge, le, ne and negative flags unchanged.
// RULE_12 - Range compare sets error flag when low limit exceeds high limit.
// RULE_13 - Result and flags update together one cycle after issue, else hold; a Wishbone write to OFS_FLAGS also loads the flags.
// RULE_14 - Sequencer holds operands stable and waits for completion.
module trc_unit (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic [11:0] op_i,
	input wire logic [15:0] src_i,
	input wire logic [511:0] block_i,
	input wire logic [31:0] compare_value_i,
	input wire logic [31:0] low_limit_i,
	input wire logic [31:0] high_limit_i,
	output logic done_o,
	output logic [15:0] result_o,
	output logic error_flag_out_o,
	output logic equal_flag_out_o,
	output logic greater_flag_out_o,
	output logic less_flag_out_o,
	output logic ge_flag_out_o,
	output logic le_flag_out_o,
	output logic ne_flag_out_o,
	output logic neg_flag_out_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);

	logic enable;
	logic [7:0] flags;
	logic [7:0] next_flags;
	logic [15:0] next_result;
	logic [15:0] tbl_hit;
	logic [15:0] blk_hit;

	////////////////////////////////////////////////////////////////////////////
	// Sixteen table matches and sixteen block ranges, evaluated in parallel.
	for (genvar i = 0; i < trc_pkg::N_RANGES; i++)
	begin : g_cmp
		wire [15:0] tbl_word = block_i[trc_pkg::WORD_W*i +: trc_pkg::WORD_W];
		wire [15:0] lo_word = block_i[trc_pkg::WORD_W*(2*i) +: trc_pkg::WORD_W]; // see RULE_03
		wire [15:0] hi_word = block_i[trc_pkg::WORD_W*(2*i+1) +: trc_pkg::WORD_W]; // see RULE_03
		assign tbl_hit[i] = (tbl_word == src_i); // see RULE_01
		// An inverted pair can never hold the source, so the bit is zero.
		assign blk_hit[i] = (lo_word <= src_i) && (src_i <= hi_word); // see RULE_04, RULE_05
	end

	////////////////////////////////////////////////////////////////////////////
	// Operation decode and range comparison in 16-bit or 32-bit width.
	wire is_tbl = (op_i == trc_pkg::OP_TABLE_CMP);
	wire is_blk = (op_i == trc_pkg::OP_BLOCK_CMP); // see RULE_07
	wire is_rng = (op_i == trc_pkg::OP_RANGE_CMP); // see RULE_08
	wire is_drng = (op_i == trc_pkg::OP_DRANGE_CMP); // see RULE_09
	wire issue = start_i && enable;
	wire [31:0] cv = is_drng ? compare_value_i : {16'h0000, compare_value_i[15:0]}; // see RULE_08, RULE_09
	wire [31:0] ll = is_drng ? low_limit_i : {16'h0000, low_limit_i[15:0]};
	wire [31:0] hl = is_drng ? high_limit_i : {16'h0000, high_limit_i[15:0]};
	wire rng_gt = cv > hl;
	wire rng_lt = cv < ll;
	wire rng_eq = (ll <= cv) && (cv <= hl);
	wire rng_err = ll > hl;

	////////////////////////////////////////////////////////////////////////////
	// Wishbone decode; the flag write lands on the edge that sees ack high.
	wire wb_req = wb_cyc_i && wb_stb_i;
	wire wb_wr = wb_req && wb_we_i && wb_ack_o && wb_sel_i[0];
	wire sel_ctrl = (wb_adr_i == trc_pkg::OFS_CTRL);
	wire sel_flags = (wb_adr_i == trc_pkg::OFS_FLAGS);
	wire sel_result = (wb_adr_i == trc_pkg::OFS_RESULT);
	wire [31:0] rd_mux = sel_ctrl ? {31'h00000000, enable} :
		sel_flags ? {24'h000000, flags} :
		sel_result ? {16'h0000, result_o} : 32'h00000000;

	////////////////////////////////////////////////////////////////////////////
	// Next result and flags; ops that are not issued leave everything alone.
	always_comb
	begin
		next_result = result_o;
		next_flags = flags;
		if (wb_wr && sel_flags)
		begin
			next_flags = wb_dat_i[7:0];
		end
		if (issue && is_tbl)
		begin
			next_result = tbl_hit;
			next_flags[trc_pkg::FL_EQ] = (tbl_hit == 16'h0000); // see RULE_02
			next_flags[trc_pkg::FL_ER] = 1'b0; // see RULE_02
		end
		else if (issue && is_blk)
		begin
			next_result = blk_hit; // see RULE_07
			next_flags[trc_pkg::FL_EQ] = (blk_hit == 16'h0000); // see RULE_06
			next_flags[trc_pkg::FL_ER] = 1'b0; // see RULE_05, RULE_06
		end
		else if (issue && (is_rng || is_drng))
		begin
			// Only four flags move; ge, le, ne and negative keep their value.
			next_flags[trc_pkg::FL_GT] = rng_gt; // see RULE_10, RULE_11
			next_flags[trc_pkg::FL_EQ] = rng_eq; // see RULE_10
			next_flags[trc_pkg::FL_LT] = rng_lt; // see RULE_10
			next_flags[trc_pkg::FL_ER] = rng_err; // see RULE_12
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State registers: result, flags and a completion pulse in one edge.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			result_o <= trc_pkg::RESULT_RST;
			flags <= trc_pkg::FLAGS_RST;
			done_o <= 1'b0;
		end
		else
		begin
			result_o <= next_result; // see RULE_13
			flags <= next_flags; // see RULE_13
			done_o <= issue; // see RULE_13
		end
	end

	// Bus registers: control bit, acknowledge and read data.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			enable <= trc_pkg::CTRL_RST;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			if (wb_wr && sel_ctrl)
			begin
				enable <= wb_dat_i[0];
			end
			wb_ack_o <= wb_req && !wb_ack_o;
			wb_dat_o <= rd_mux;
		end
	end

	// Flag outputs.
	assign error_flag_out_o = flags[trc_pkg::FL_ER];
	assign equal_flag_out_o = flags[trc_pkg::FL_EQ];
	assign greater_flag_out_o = flags[trc_pkg::FL_GT];
	assign less_flag_out_o = flags[trc_pkg::FL_LT];
	assign ge_flag_out_o = flags[trc_pkg::FL_GE];
	assign le_flag_out_o = flags[trc_pkg::FL_LE];
	assign ne_flag_out_o = flags[trc_pkg::FL_NE];
	assign neg_flag_out_o = flags[trc_pkg::FL_N];

	////////////////////////////////////////////////////////////////////////////
	// Checks on the completed operations.
	sequence s_issue_rng;
		issue && (is_rng || is_drng);
	endsequence
	sequence s_quiet;
		!issue && !wb_wr;
	endsequence

	property p_tbl_bit0;
		@(posedge clk_i) disable iff (rst_i)
		issue && is_tbl |=> result_o[0] == $past(block_i[15:0] == src_i);
	endproperty
	a_tbl_bit0: assert property (p_tbl_bit0) else $error("table bit 0 wrong"); // see RULE_01

	property p_tbl_flags;
		@(posedge clk_i) disable iff (rst_i)
		issue && is_tbl |=> !error_flag_out_o && (equal_flag_out_o == (result_o == 16'h0000));
	endproperty
	a_tbl_flags: assert property (p_tbl_flags) else $error("table flags wrong"); // see RULE_02

	property p_blk_bit15;
		@(posedge clk_i) disable iff (rst_i)
		issue && is_blk |=> result_o[15] ==
			$past((block_i[495:480] <= src_i) && (src_i <= block_i[511:496]));
	endproperty
	a_blk_bit15: assert property (p_blk_bit15) else $error("block bit 15 wrong"); // see RULE_03

	property p_blk_inverted;
		@(posedge clk_i) disable iff (rst_i)
		issue && is_blk && (block_i[15:0] > block_i[31:16]) |=> !result_o[0] && !error_flag_out_o;
	endproperty
	a_blk_inverted: assert property (p_blk_inverted) else $error("inverted range set bit"); // see RULE_05

	property p_blk_flags;
		@(posedge clk_i) disable iff (rst_i)
		issue && is_blk |=> equal_flag_out_o == (result_o == 16'h0000);
	endproperty
	a_blk_flags: assert property (p_blk_flags) else $error("block equal flag wrong"); // see RULE_06

	property p_rng_one_hot;
		@(posedge clk_i) disable iff (rst_i)
		s_issue_rng ##0 !rng_err |=> $onehot({greater_flag_out_o, equal_flag_out_o, less_flag_out_o})
			&& $stable(result_o);
	endproperty
	a_rng_one_hot: assert property (p_rng_one_hot) else $error("range flags not exclusive"); // see RULE_10

	property p_rng_keep;
		@(posedge clk_i) disable iff (rst_i)
		s_issue_rng ##0 !wb_wr |=> $stable({ge_flag_out_o, le_flag_out_o, ne_flag_out_o, neg_flag_out_o});
	endproperty
	a_rng_keep: assert property (p_rng_keep) else $error("range compare touched other flags"); // see RULE_11

	property p_rng_err;
		@(posedge clk_i) disable iff (rst_i)
		s_issue_rng |=> error_flag_out_o == $past(rng_err);
	endproperty
	a_rng_err: assert property (p_rng_err) else $error("range error flag wrong"); // see RULE_12

	property p_hold;
		@(posedge clk_i) disable iff (rst_i)
		s_quiet |=> $stable(result_o) && $stable(flags) && !done_o;
	endproperty
	a_hold: assert property (p_hold) else $error("outputs moved without an operation"); // see RULE_13

	property p_done;
		@(posedge clk_i) disable iff (rst_i)
		issue |-> ##1 done_o;
	endproperty
	a_done: assert property (p_done) else $error("completion pulse missing"); // see RULE_13

endmodule // trc_unit

// >>> verif/trc_seq_model.sv
// Purpose: Sequencer model that issues compare operations to the unit.
// Assumes: Completion comes back as a one-cycle done pulse.
// Notes: Operands are scrambled once an operation has completed.
module trc_seq_model (
	input wire logic clk_i,
	input wire logic done_i,
	output logic start_o,
	output logic [11:0] op_o,
	output logic [15:0] src_o,
	output logic [511:0] block_o,
	output logic [31:0] cv_o,
	output logic [31:0] lo_o,
	output logic [31:0] hi_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle values at time zero.
	initial
	begin
		{start_o, op_o, src_o, block_o, cv_o, lo_o, hi_o} = '0;
	end

	// Issues one operation and counts edges to done; zero means no answer came.
	task automatic issue(input logic [11:0] op, input logic [15:0] src,
		input logic [511:0] blk, input logic [31:0] cv, input logic [31:0] lo,
		input logic [31:0] hi, output int lat);
		lat = 0;
		@(posedge clk_i);
		start_o <= 1'b1;
		op_o <= op;
		{src_o, block_o, cv_o, lo_o, hi_o} <= {src, blk, cv, lo, hi};
		@(posedge clk_i);
		start_o <= 1'b0;
		for (int i = 1; i <= 4 && lat == 0; i++)
		begin
			@(posedge clk_i);
			if (done_i === 1'b1)
				lat = i;
		end
		// Operands stay put until completion, or for four edges when none comes, then no longer hold.
		{src_o, block_o, cv_o, lo_o, hi_o} <= ~{src, blk, cv, lo, hi};
	endtask
endmodule // trc_seq_model

// >>> verif/testbench.sv
// Purpose: Self-checking bench for the table and range compare unit.
// Assumes: The sequencer model issues operations; the bench drives Wishbone.
// Notes: The flag vector follows the flag register bit order.
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst, st, dn, cyc, stb, we, ack;
	logic [11:0] op;
	logic [15:0] src, res;
	logic [511:0] blk;
	logic [31:0] cv, lo, hi, wd, rd, q;
	logic [7:0] fl;
	logic [3:0] adr;
	int err_count = 0;
	int checked = 0;
	int lat;

	trc_seq_model seq (.clk_i(clk), .done_i(dn), .start_o(st), .op_o(op), .src_o(src),
		.block_o(blk), .cv_o(cv), .lo_o(lo), .hi_o(hi));
	trc_unit DUT (.clk_i(clk), .rst_i(rst), .start_i(st), .op_i(op), .src_i(src),
		.block_i(blk), .compare_value_i(cv), .low_limit_i(lo), .high_limit_i(hi),
		.done_o(dn), .result_o(res), .error_flag_out_o(fl[0]), .equal_flag_out_o(fl[1]),
		.greater_flag_out_o(fl[2]), .less_flag_out_o(fl[3]), .ge_flag_out_o(fl[4]),
		.le_flag_out_o(fl[5]), .ne_flag_out_o(fl[6]), .neg_flag_out_o(fl[7]),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack));

	////////////////////////////////////////////////////////////////////////////////
	// Compares one value and counts the outcome.
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// One classic Wishbone cycle; read data is taken at the ack edge.
	// The wait has no limit of its own, so only the watchdog ends a hung cycle.
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		{cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
		while (ack !== 1'b1)
			@(posedge clk);
		q = rd;
		{cyc, stb} <= 2'b00;
	endtask

	// Reads a register and compares it.
	task automatic rchk(input logic [3:0] a, input logic [31:0] e);
		wb(1'b0, a, '0);
		chk(q, e);
	endtask

	// Issues an operation and checks latency, result and flags at completion.
	task automatic run(input logic [11:0] o, input logic [15:0] s, input logic [511:0] b,
		input logic [31:0] c, input logic [31:0] l, input logic [31:0] h,
		input logic [15:0] er, input logic [7:0] ef);
		seq.issue(o, s, b, c, l, h, lat);
		chk(lat, trc_pkg::DONE_LAT);
		chk(res, er);
		chk(fl, ef);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Reset values, a read-only result and an unmapped address.
	task automatic t_regs();
		rchk(trc_pkg::OFS_CTRL, 32'h00000001);
		rchk(trc_pkg::OFS_FLAGS, 32'h00000000);
		wb(1'b1, trc_pkg::OFS_RESULT, 32'h0000FFFF);
		rchk(trc_pkg::OFS_RESULT, 32'h00000000);
		wb(1'b1, 4'hC, 32'h000000FF);
		rchk(4'hC, 32'h00000000);
	endtask

	// Table compare: no match, then matches at the first, a middle and the last word.
	task automatic t_table();
		logic [511:0] b;
		b = {32{16'hA5A5}};
		for (int k = 1; k < 15; k++)
			if (k != 7)
				b[16*k+:16] = 16'h1000 + 16'(k);
		wb(1'b1, trc_pkg::OFS_FLAGS, 32'h000000FF);
		run(trc_pkg::OP_TABLE_CMP, 16'h0001, b, '0, '0, '0, 16'h0000, 8'hFE);
		run(trc_pkg::OP_TABLE_CMP, 16'hA5A5, b, '0, '0, '0, 16'h8081, 8'hFC);
	endtask

	// Range compares at and beyond both limits; upper halves are junk for one word.
	task automatic t_range();
		logic [31:0] c [9] = '{32'hFFFF0004, 32'hFFFF0005, 32'hFFFF001F, 32'h00000020,
			32'h00000015, 32'h0000FFFF, 32'h00010000, 32'h0002FFFF, 32'h00030000};
		logic [3:0] e [9] = '{4'h8, 4'h2, 4'h2, 4'h4, 4'hD, 4'h8, 4'h2, 4'h2, 4'h4};
		logic [11:0] o;
		logic [31:0] lw, hw;
		wb(1'b1, trc_pkg::OFS_FLAGS, 32'h000000F0);
		for (int i = 0; i < 9; i++)
		begin
			o = (i < 5) ? trc_pkg::OP_RANGE_CMP : trc_pkg::OP_DRANGE_CMP;
			lw = (i < 4) ? 32'hFFFF0005 : (i == 4) ? 32'h00000020 : 32'h00010000;
			hw = (i < 4) ? 32'h0000001F : (i == 4) ? 32'hFFFF0010 : 32'h0002FFFF;
			run(o, '0, '0, c[i], lw, hw, 16'h8081, {4'hF, e[i]});
		end
	endtask

	// Block compare with bounds on the source, a window above it and inverted pairs.
	task automatic t_block();
		logic [511:0] b;
		for (int n = 0; n < 16; n++)
			case (n % 4)
				0: b[32*n+:32] = {16'h0100, 16'h0100};
				1: b[32*n+:32] = {16'hFFFF, 16'h0101};
				2: b[32*n+:32] = {16'h00FF, 16'h0101};
				default: b[32*n+:32] = {16'h0100, 16'h0000};
			endcase
		wb(1'b1, trc_pkg::OFS_FLAGS, 32'h000000FF);
		run(trc_pkg::OP_BLOCK_CMP, 16'h0100, b, '0, '0, '0, 16'h9999, 8'hFC);
		b = {16{32'h0000FFFF}};
		run(trc_pkg::OP_BLOCK_CMP, 16'h0100, b, '0, '0, '0, 16'h0000, 8'hFE);
	endtask

	// A start while disabled brings no completion and changes nothing.
	task automatic t_off();
		wb(1'b1, trc_pkg::OFS_CTRL, 32'h00000000);
		seq.issue(trc_pkg::OP_TABLE_CMP, 16'h0000, '0, '0, '0, '0, lat);
		chk(lat, 0);
		chk(res, 16'h0000);
		chk(fl, 8'hFE);
		wb(1'b1, trc_pkg::OFS_CTRL, 32'h00000001);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then stops.
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Clock at 40 MHz.
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Watchdog at 3000 cycles, well beyond the roughly 80 cycles the scenarios need.
	initial
	begin
		#(25 * 3000);
		err_count++;
		end_sim();
	end

	// Reset for two cycles, then the scenarios in turn.
	initial
	begin
		{rst, cyc, stb, we, adr, wd} = {1'b1, 39'h0};
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_table();
		t_range();
		t_block();
		t_off();
		end_sim();
	end
endmodule // testbench
